/* File: pds_pkg.sv */
// Package with register map, field layout and reset values for the pin direction registers
package pds_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_DRIVE_SELECT = 12'h000;
    localparam logic [11:0] OFF_CLEAR_ALIAS = 12'h004;
    localparam logic [11:0] OFF_SET_ALIAS = 12'h008;
    localparam logic [11:0] OFF_FLIP_ALIAS = 12'h00c;
    localparam logic [11:0] OFF_GUARD_STATUS = 12'h010;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 32;
    localparam int ADDR_BITS = 12;
    localparam logic [31:0] DRIVE_SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Write operation selected by the decoded offset
    typedef enum logic [2:0] {
        PDS_OP_NONE,
        PDS_OP_WRITE,
        PDS_OP_CLEAR,
        PDS_OP_SET,
        PDS_OP_FLIP
    } pds_op_e;

endpackage : pds_pkg

/* File: pds_wr_if.sv */
// Interface carrying an accepted register write from the bus slave to the direction store
`timescale 1ns/1ps
interface pds_wr_if;
    logic valid;
    pds_pkg::pds_op_e op;
    logic [31:0] lane_mask;
    logic [31:0] data;
    logic [31:0] value;

    modport slave (output valid, output op, output lane_mask, output data, input value);
    modport store (input valid, input op, input lane_mask, input data, output value);
endinterface : pds_wr_if

/* File: pds_store.sv */
// Direction storage shared by the direct register and its clear, set and flip aliases
`timescale 1ns/1ps
module pds_store (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Write port
    pds_wr_if.store wr
);

    logic [31:0] drive_select;

    // ------------------------------------------------------------
    // Update of the single shared direction word
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            drive_select <= pds_pkg::DRIVE_SELECT_RESET;
        end else if (wr.valid) begin
            case (wr.op)
                pds_pkg::PDS_OP_WRITE: begin
                    drive_select <= (drive_select & ~wr.lane_mask) | (wr.data & wr.lane_mask);
                end
                pds_pkg::PDS_OP_CLEAR: begin
                    drive_select <= drive_select & ~(wr.data & wr.lane_mask);
                end
                pds_pkg::PDS_OP_SET: begin
                    drive_select <= drive_select | (wr.data & wr.lane_mask);
                end
                pds_pkg::PDS_OP_FLIP: begin
                    drive_select <= drive_select ^ (wr.data & wr.lane_mask);
                end
                default: begin
                    drive_select <= drive_select;
                end
            endcase
        end
    end

    assign wr.value = drive_select;

endmodule : pds_store

/* File: pds_dir_regs.sv */
// Top of the pin direction register block with its AHB-Lite slave
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps

// Behaviour
// - Single 8, 16, 32-bit accesses complete atomically
// - Each lane writable alone, others unchanged
// - Guard enabled suppresses writes, reads allowed
// - Direction is 32 bits, resets zero
// - Bit 0 input, bit 1 output
// - Clear alias ones force bits zero
// - Set alias ones force bits one
// - Flip alias reverses selected pins
// - Flip ones invert, zeros keep
// - All four addresses read shared direction
// - Offsets 0x00, 0x04, 0x08, 0x0c
module pds_dir_regs (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [11:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Peripheral write guard
    input wire logic i_write_guard,
    // Pad drivers
    output logic [31:0] o_pad_drive_n,
    output logic [31:0] o_pin_output
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Byte enables of one access from size and low address bits
    function automatic logic [3:0] lane_enables(input logic [2:0] size, input logic [1:0] low);
        logic [3:0] en;
        en = 4'h0;
        case (size)
            pds_pkg::HSIZE_BYTE: en = 4'h1 << low;
            pds_pkg::HSIZE_HALF: en = low[1] ? 4'hc : 4'h3;
            pds_pkg::HSIZE_WORD: en = 4'hf;
            default: en = 4'h0;
        endcase
        return en;
    endfunction : lane_enables

    // Word offset of a byte address; the low bits only pick lanes
    function automatic logic [11:0] word_offset(input logic [11:0] addr);
        return {addr[11:2], 2'h0};
    endfunction : word_offset

    // Operation of a word offset; unmapped offsets do nothing
    function automatic pds_pkg::pds_op_e offset_op(input logic [11:0] addr);
        pds_pkg::pds_op_e op;
        op = pds_pkg::PDS_OP_NONE;
        case (word_offset(addr))
            pds_pkg::OFF_DRIVE_SELECT: op = pds_pkg::PDS_OP_WRITE;
            pds_pkg::OFF_CLEAR_ALIAS: op = pds_pkg::PDS_OP_CLEAR;
            pds_pkg::OFF_SET_ALIAS: op = pds_pkg::PDS_OP_SET;
            pds_pkg::OFF_FLIP_ALIAS: op = pds_pkg::PDS_OP_FLIP;
            default: op = pds_pkg::PDS_OP_NONE;
        endcase
        return op;
    endfunction : offset_op

    // ------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------
    logic addr_take;
    logic ph_write;
    logic ph_read;
    logic [11:0] ph_addr;
    logic [3:0] ph_lanes;
    logic ph_guard;
    logic [31:0] current;
    pds_wr_if wr ();

    assign addr_take = i_hsel && i_hready && (i_htrans == pds_pkg::HTRANS_NONSEQ);

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ph_write <= 1'b0;
            ph_read <= 1'b0;
            ph_addr <= 12'h000;
            ph_lanes <= 4'h0;
            ph_guard <= 1'b0;
        end else if (i_hready) begin
            ph_write <= addr_take && i_hwrite;
            ph_read <= addr_take && !i_hwrite;
            ph_addr <= i_haddr;
            ph_lanes <= lane_enables(i_hsize, i_haddr[1:0]);
            ph_guard <= i_write_guard;
        end
    end

    // Data phase always finishes in one cycle with OKAY
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read data, registered in the address phase
    // ------------------------------------------------------------
    // Read data is computed from the value after any write landing in this
    // same edge, so a read right behind a write sees the new direction.
    logic [31:0] next_value;

    always_comb begin
        next_value = current;
        if (wr.valid) begin
            case (wr.op)
                pds_pkg::PDS_OP_WRITE: next_value = (current & ~wr.lane_mask) | (wr.data & wr.lane_mask);
                pds_pkg::PDS_OP_CLEAR: next_value = current & ~(wr.data & wr.lane_mask);
                pds_pkg::PDS_OP_SET: next_value = current | (wr.data & wr.lane_mask);
                pds_pkg::PDS_OP_FLIP: next_value = current ^ (wr.data & wr.lane_mask);
                default: next_value = current;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_hrdata <= pds_pkg::READ_ZERO;
        end else if (addr_take && !i_hwrite) begin
            if (word_offset(i_haddr) == pds_pkg::OFF_GUARD_STATUS) begin
                o_hrdata <= {31'h0, i_write_guard};
            end else if (offset_op(i_haddr) != pds_pkg::PDS_OP_NONE) begin
                o_hrdata <= next_value;
            end else begin
                o_hrdata <= pds_pkg::READ_ZERO;
            end
        end
    end

    // ------------------------------------------------------------
    // Write path into the shared store
    // ------------------------------------------------------------
    always_comb begin
        wr.valid = ph_write && !ph_guard;
        wr.op = offset_op(ph_addr);
        wr.data = i_hwdata;
        wr.lane_mask = {{8{ph_lanes[3]}}, {8{ph_lanes[2]}}, {8{ph_lanes[1]}}, {8{ph_lanes[0]}}};
    end

    assign current = wr.value;

    pds_store u_store (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .wr(wr)
    );

    // ------------------------------------------------------------
    // Pad outputs
    // ------------------------------------------------------------
    // Own flops load the same next value as the store, so the pads change on
    // the edge that lands a write while the outputs still come from registers.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_pin_output <= pds_pkg::DRIVE_SELECT_RESET;
            o_pad_drive_n <= ~pds_pkg::DRIVE_SELECT_RESET;
        end else begin
            o_pin_output <= next_value;
            o_pad_drive_n <= ~next_value;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Bits picked by the lanes and data of the write now in its data phase
    logic [31:0] sel_bits;

    assign sel_bits = wr.data & wr.lane_mask;

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // Write data phase allowed to reach the store
    sequence s_write_taken;
        ph_write && !ph_guard;
    endsequence

    // Write data phase held back by the guard
    sequence s_guarded_write;
        ph_write && ph_guard;
    endsequence

    // Write data phase at an offset with no direction alias behind it
    sequence s_unmapped_write;
        ph_write && (offset_op(ph_addr) == pds_pkg::PDS_OP_NONE);
    endsequence

    // Read address phase at one of the four direction offsets
    sequence s_dir_read;
        addr_take && !i_hwrite && (offset_op(i_haddr) != pds_pkg::PDS_OP_NONE);
    endsequence

    // Data phase of a direction read, while the loaded word stands
    sequence s_dir_read_data;
        ph_read && (offset_op(ph_addr) != pds_pkg::PDS_OP_NONE);
    endsequence

    // Read address phase at the guard status word
    sequence s_status_read;
        addr_take && !i_hwrite && (word_offset(i_haddr) == pds_pkg::OFF_GUARD_STATUS);
    endsequence

    // Read address phase at an offset that maps to nothing
    sequence s_unmapped_read;
        addr_take && !i_hwrite && (offset_op(i_haddr) == pds_pkg::PDS_OP_NONE) &&
            (word_offset(i_haddr) != pds_pkg::OFF_GUARD_STATUS);
    endsequence

    // ------------------------------------------------------------
    // Reset checks
    // ------------------------------------------------------------
    a_reset_zero: assert property (@(posedge i_clk)
        !i_reset_n |=> (current == pds_pkg::DRIVE_SELECT_RESET))
        else $error("direction not zero after reset");

    a_pad_reset: assert property (@(posedge i_clk)
        !i_reset_n |=> (o_pin_output == pds_pkg::DRIVE_SELECT_RESET) &&
            (o_pad_drive_n == ~pds_pkg::DRIVE_SELECT_RESET))
        else $error("pads not released to inputs by reset");

    a_reset_bus: assert property (@(posedge i_clk)
        !i_reset_n |=> o_hreadyout && !o_hresp && (o_hrdata == pds_pkg::READ_ZERO))
        else $error("bus outputs wrong after reset");

    // ------------------------------------------------------------
    // Lane decode checks
    // ------------------------------------------------------------
    a_byte_lanes: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (addr_take && (i_hsize == pds_pkg::HSIZE_BYTE)) |=> ($countones(ph_lanes) == 1))
        else $error("byte access not one lane");

    a_half_lanes: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (addr_take && (i_hsize == pds_pkg::HSIZE_HALF)) |=> ((ph_lanes == 4'h3) || (ph_lanes == 4'hc)))
        else $error("half access not one aligned half");

    a_word_lanes: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (addr_take && (i_hsize == pds_pkg::HSIZE_WORD)) |=> (ph_lanes == 4'hf))
        else $error("word access not all lanes");

    // ------------------------------------------------------------
    // Store update checks
    // ------------------------------------------------------------
    a_lane_write: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_write_taken and (wr.op == pds_pkg::PDS_OP_WRITE)) |=>
        ((current & $past(wr.lane_mask)) == ($past(wr.data) & $past(wr.lane_mask))))
        else $error("write missed its lanes");

    a_lane_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_write_taken and (wr.op == pds_pkg::PDS_OP_WRITE)) |=>
        ((current & ~$past(wr.lane_mask)) == ($past(current) & ~$past(wr.lane_mask))))
        else $error("write disturbed other lanes");

    a_clear_bits: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_write_taken and (wr.op == pds_pkg::PDS_OP_CLEAR)) |=>
        ((current & $past(sel_bits)) == 32'h0000_0000))
        else $error("clear alias left bits set");

    a_clear_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_write_taken and (wr.op == pds_pkg::PDS_OP_CLEAR)) |=>
        ((current & ~$past(sel_bits)) == ($past(current) & ~$past(sel_bits))))
        else $error("clear alias touched unselected bits");

    a_set_bits: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_write_taken and (wr.op == pds_pkg::PDS_OP_SET)) |=>
        ((current & $past(sel_bits)) == $past(sel_bits)))
        else $error("set alias left bits clear");

    a_set_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_write_taken and (wr.op == pds_pkg::PDS_OP_SET)) |=>
        ((current & ~$past(sel_bits)) == ($past(current) & ~$past(sel_bits))))
        else $error("set alias touched unselected bits");

    a_flip_bits: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_write_taken and (wr.op == pds_pkg::PDS_OP_FLIP)) |=>
        (current == ($past(current) ^ $past(sel_bits))))
        else $error("flip alias wrong result");

    // ------------------------------------------------------------
    // Guard and unmapped write checks
    // ------------------------------------------------------------
    a_guard_blocks: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_guarded_write |=> (current == $past(current)))
        else $error("guarded write changed direction");

    a_guard_pads: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_guarded_write |=> (o_pin_output == $past(o_pin_output)))
        else $error("guarded write moved the pads");

    a_guard_reads: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (s_dir_read and i_write_guard) |=> (o_hrdata == current))
        else $error("read refused while guarded");

    a_unmapped_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_unmapped_write |=> (current == $past(current)))
        else $error("unmapped write changed direction");

    // ------------------------------------------------------------
    // Read data checks
    // ------------------------------------------------------------
    a_alias_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_dir_read |=> (o_hrdata == current))
        else $error("alias read differs from direction");

    a_read_data: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_dir_read_data |-> (o_hrdata == current))
        else $error("read data phase differs from direction");

    a_status_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_status_read |=> (o_hrdata == {31'h0, $past(i_write_guard)}))
        else $error("status word not showing guard");

    a_unmapped_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_unmapped_read |=> (o_hrdata == pds_pkg::READ_ZERO))
        else $error("unmapped read not zero");

    // ------------------------------------------------------------
    // Pad checks
    // ------------------------------------------------------------
    a_pad_follow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ##1 (o_pad_drive_n == ~current) && (o_pin_output == current))
        else $error("pad enable not following direction");

    a_pad_inverse: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_pad_drive_n == ~o_pin_output)
        else $error("pad enable not inverse of direction");

endmodule : pds_dir_regs

/* File: pds_pad_model.sv */
// Behavioural model of the pad drivers that sit behind the direction outputs
`timescale 1ns/1ps
module pds_pad_model (
    // Pad enables from the block
    input wire logic [31:0] i_pad_drive_n,
    // Pad state seen by the bench
    output logic [31:0] o_pad_is_output
);
    // A low enable drives the pad, so that pin acts as an output
    assign o_pad_is_output = ~i_pad_drive_n;
endmodule : pds_pad_model

/* File: io_pin_direction_regs_tb_top.sv */
// Self-checking testbench for the pin direction register block
`timescale 1ns/1ps
module io_pin_direction_regs_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic guard = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] pad_drive_n;
    logic [31:0] pin_output;
    logic [31:0] pad_is_output;
    logic [31:0] dir;
    logic [31:0] rd;
    int n_errors = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    pds_dir_regs uut (.i_clk(clk), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
        .o_hreadyout(hreadyout), .o_hresp(hresp), .i_write_guard(guard), .o_pad_drive_n(pad_drive_n),
        .o_pin_output(pin_output));
    pds_pad_model pads_m (.i_pad_drive_n(pad_drive_n), .o_pad_is_output(pad_is_output));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            final_report();
        end
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [11:0] a, input logic [2:0] sz, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        htrans <= pds_pkg::HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= pds_pkg::HTRANS_IDLE;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, pds_pkg::HSIZE_WORD, d);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, pds_pkg::HSIZE_WORD, 32'h0000_0000);
        check("read word", rd, exp);
    endtask : rdchk
    // Pads move on the edge that lands the write; this checks them one edge after the write completes
    task automatic pads(input logic [31:0] exp);
        @(posedge clk);
        check("pin_output", pin_output, exp);
        check("pad_is_output", pad_is_output, exp);
    endtask : pads
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        pads(32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            rdchk(12'(i * 4), pds_pkg::DRIVE_SELECT_RESET);
        end
    endtask : t_reset_values
    task automatic t_alias_ops;
        dir = 32'ha5a5_0f0f;
        wr(pds_pkg::OFF_DRIVE_SELECT, dir);
        pads(dir);
        wr(pds_pkg::OFF_SET_ALIAS, 32'h0000_00f0);
        dir = dir | 32'h0000_00f0;
        pads(dir);
        wr(pds_pkg::OFF_CLEAR_ALIAS, 32'h8000_000f);
        dir = dir & ~32'h8000_000f;
        pads(dir);
        wr(pds_pkg::OFF_FLIP_ALIAS, 32'hffff_0000);
        wr(pds_pkg::OFF_FLIP_ALIAS, 32'h0f00_0001);
        dir = dir ^ 32'hffff_0000 ^ 32'h0f00_0001;
        for (int i = 0; i < 4; i++) begin
            rdchk(12'(i * 4), dir);
        end
    endtask : t_alias_ops
    task automatic t_lanes;
        wr(pds_pkg::OFF_DRIVE_SELECT, 32'h0000_0000);
        bus(1'b1, 12'h001, pds_pkg::HSIZE_BYTE, 32'h0000_ab00);
        bus(1'b1, pds_pkg::OFF_SET_ALIAS + 12'h002, pds_pkg::HSIZE_HALF, 32'h00f0_0000);
        bus(1'b1, pds_pkg::OFF_FLIP_ALIAS + 12'h003, pds_pkg::HSIZE_BYTE, 32'hff00_0000);
        dir = 32'hff00_0000 | 32'h00f0_0000 | 32'h0000_ab00;
        rdchk(pds_pkg::OFF_DRIVE_SELECT, dir);
        bus(1'b0, 12'h003, pds_pkg::HSIZE_BYTE, 32'h0000_0000);
        check("byte read", {24'h0, rd[31:24]}, {24'h0, dir[31:24]});
    endtask : t_lanes
    task automatic t_guard;
        guard <= 1'b1;
        wr(pds_pkg::OFF_DRIVE_SELECT, 32'h1234_5678);
        wr(pds_pkg::OFF_SET_ALIAS, 32'hffff_ffff);
        wr(pds_pkg::OFF_FLIP_ALIAS, 32'hffff_ffff);
        pads(dir);
        rdchk(pds_pkg::OFF_DRIVE_SELECT, dir);
        rdchk(pds_pkg::OFF_GUARD_STATUS, 32'h0000_0001);
        guard <= 1'b0;
        rdchk(12'h020, pds_pkg::READ_ZERO);
        wr(pds_pkg::OFF_GUARD_STATUS, 32'h0000_0000);
        rdchk(pds_pkg::OFF_DRIVE_SELECT, dir);
        wr(pds_pkg::OFF_CLEAR_ALIAS, 32'hffff_ffff);
        pads(32'h0000_0000);
    endtask : t_guard
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        t_reset_values();
        t_alias_ops();
        t_lanes();
        t_guard();
        final_report();
    end
endmodule : io_pin_direction_regs_tb_top
